// [pkg/aog_defs.svh]
`ifndef AOG_DEFS_SVH
`define AOG_DEFS_SVH

// ==========================================
// address steps for auto-update addressing
`define AOG_STEP_BYTE    16'h0001
`define AOG_STEP_WORD    16'h0002

// ==========================================
// special function register window
`define AOG_SFR_PAGE     4'hf
`define AOG_SFR_OFF_W    8

// ==========================================
// bit number field widths
`define AOG_BITNUM_BYTE  3
`define AOG_BITNUM_WORD  4

// ==========================================
// reset values
`define AOG_RST_WORD     16'h0000
`define AOG_RST_PHYS     20'h00000

`endif

// [pkg/aog_pkg.sv]
package aog_pkg;

  // ==========================================
  // addressing modes
  typedef enum logic [2:0] {
    AOG_MODE_NONE   = 3'b000,
    AOG_MODE_REGIND = 3'b001,
    AOG_MODE_AUTO   = 3'b010,
    AOG_MODE_INDEX  = 3'b011,
    AOG_MODE_BASED  = 3'b100,
    AOG_MODE_BASIDX = 3'b101,
    AOG_MODE_SFR    = 3'b110,
    AOG_MODE_DIRECT = 3'b111
  } aog_mode_t;

  // ==========================================
  // bit manipulations
  typedef enum logic [1:0] {
    AOG_BIT_TEST   = 2'b00,
    AOG_BIT_SET    = 2'b01,
    AOG_BIT_CLEAR  = 2'b10,
    AOG_BIT_INVERT = 2'b11
  } aog_bit_op_t;

  // ==========================================
  // registered state of the generator
  typedef struct packed {
    logic        done;
    logic [15:0] ea;
    logic [19:0] sfr_addr;
    logic        is_sfr;
    logic        illegal;
    logic [15:0] idx_new;
    logic        idx_we;
    logic        idx_dst;
    logic [15:0] rep_new;
    logic        rep_we;
    logic        rep_last;
    logic [3:0]  gpr_sel;
    logic [1:0]  sreg_sel;
    logic [3:0]  bit_sel;
    logic        bit_val;
    logic [15:0] bit_result;
  } aog_state_t;

endpackage

// [sim/aog_top_checker.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// port checks, one clock domain
module aog_top_checker
  import aog_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  input wire logic        req_i,
  input var  aog_mode_t   mode_i,
  input wire logic        word_i,
  input wire logic        direction_flag_i,
  input wire logic        block_dst_i,
  input wire logic        block_rep_i,
  input wire logic [1:0]  mem_sel_i,
  input wire logic [2:0]  reg_field_i,
  input wire logic [15:0] source_index_i,
  input wire logic [15:0] dest_index_i,
  input wire logic [15:0] repeat_counter_i,
  input wire logic [7:0]  sfr_base_select_i,
  input wire logic [15:0] disp_i,
  input wire logic        bit_test_clear_instr_i,
  input wire logic [15:0] ea_o,
  input wire logic [19:0] sfr_addr_o,
  input wire logic        is_sfr_o,
  input wire logic        illegal_o,
  input wire logic [15:0] idx_new_o,
  input wire logic        idx_we_o,
  input wire logic        idx_dst_o,
  input wire logic [15:0] rep_new_o,
  input wire logic        rep_we_o,
  input wire logic        disp_wide_i,
  input wire logic        index_sel_i,
  input wire logic        done_o,
  input wire logic [3:0]  gpr_sel_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  logic [15:0] base_x;
  logic [15:0] step_x;
  logic [19:0] sfr_x;
  logic [3:0]  gpr_x;
  logic [15:0] disp_x;
  logic [15:0] index_x;
  assign base_x  = block_dst_i ? dest_index_i : source_index_i;
  assign step_x  = word_i ? 16'h0002 : 16'h0001;
  assign sfr_x   = {sfr_base_select_i, 4'hf, disp_i[7:0]};
  assign gpr_x   = {word_i, reg_field_i};
  // short displacement counts as signed
  assign disp_x  = disp_wide_i ? disp_i : {{8{disp_i[7]}}, disp_i[7:0]};
  assign index_x = index_sel_i ? dest_index_i : source_index_i;
  sequence s_auto;
    req_i && mode_i == AOG_MODE_AUTO;
  endsequence
  sequence s_sfr;
    req_i && mode_i == AOG_MODE_SFR;
  endsequence
  sequence s_index;
    req_i && mode_i == AOG_MODE_INDEX;
  endsequence
  property p_inc;
    s_auto ##0 !direction_flag_i |=> idx_we_o && idx_new_o == $past(base_x) + $past(step_x);
  endproperty
  a_inc: assert property (p_inc) else $error("increment step wrong");
  property p_dec;
    s_auto ##0 direction_flag_i |=> idx_we_o && idx_new_o == $past(base_x) - $past(step_x);
  endproperty
  a_dec: assert property (p_dec) else $error("decrement step wrong");
  property p_dst;
    s_auto |=> idx_dst_o == $past(block_dst_i) && ea_o == $past(base_x);
  endproperty
  a_dst: assert property (p_dst) else $error("block register wrong");
  property p_rep;
    s_auto ##0 block_rep_i && repeat_counter_i > 16'h0001 |=>
      rep_we_o && rep_new_o == $past(repeat_counter_i) - 16'h0001;
  endproperty
  a_rep: assert property (p_rep) else $error("repeat count wrong");
  property p_rep_zero;
    s_auto ##0 block_rep_i && repeat_counter_i == 16'h0000 |=>
      !rep_we_o && rep_new_o == 16'h0000;
  endproperty
  a_rep_zero: assert property (p_rep_zero) else $error("empty count stepped");
  property p_once;
    !req_i |=> !done_o && !idx_we_o && !rep_we_o;
  endproperty
  a_once: assert property (p_once) else $error("update strobe without request");
  property p_sfr_ok;
    s_sfr ##0 bit_test_clear_instr_i |=> is_sfr_o && sfr_addr_o == $past(sfr_x);
  endproperty
  a_sfr_ok: assert property (p_sfr_ok) else $error("sfr address wrong");
  property p_sfr_bad;
    s_sfr ##0 !bit_test_clear_instr_i |=>
      illegal_o && !is_sfr_o && sfr_addr_o == 20'h00000 && ea_o == 16'h0000;
  endproperty
  a_sfr_bad: assert property (p_sfr_bad) else $error("sfr not refused");
  property p_gpr;
    req_i |=> done_o && gpr_sel_o == $past(gpr_x);
  endproperty
  a_gpr: assert property (p_gpr) else $error("register select wrong");
  property p_regind;
    req_i && mode_i == AOG_MODE_REGIND && mem_sel_i == 2'h0 |=> ea_o == $past(source_index_i);
  endproperty
  a_regind: assert property (p_regind) else $error("indirect address wrong");
  property p_index;
    s_index |=> ea_o == $past(index_x) + $past(disp_x);
  endproperty
  a_index: assert property (p_index) else $error("index address wrong");
endmodule
bind aog_top aog_top_checker u_chk (.*);
`default_nettype wire

// [sim/aog_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module aog_top_tb
  import aog_pkg::*;
;
  // ==========================================
  // stimulus table and design
  typedef struct {
    aog_mode_t   m;
    logic [5:0]  f;
    logic [1:0]  ms;
    logic [15:0] d, ea, idx;
  } aog_row_t;
  logic        clk_i, sys_rst_i, req_i, word_i, direction_flag_i, disp_wide_i, base_sel_i;
  logic        index_sel_i, block_dst_i, block_rep_i, bit_test_clear_instr_i, bit_op_en_i;
  logic        bit_from_count_i, done_o, is_sfr_o, illegal_o, idx_we_o, idx_dst_o, rep_we_o;
  logic        rep_last_o, bit_val_o;
  logic [1:0]  mem_sel_i, sreg_field_i, sreg_sel_o;
  logic [2:0]  reg_field_i;
  logic [3:0]  bit_imm_i, gpr_sel_o, bit_sel_o;
  logic [7:0]  count_low_byte_i, sfr_base_select_i;
  logic [15:0] disp_i, operand_i, repeat_counter_i, source_index_i, dest_index_i;
  logic [15:0] base_pointer_i, base_word_i, ea_o, idx_new_o, rep_new_o, bit_result_o;
  logic [19:0] sfr_addr_o;
  aog_mode_t   mode_i;
  aog_bit_op_t bit_op_i;
  int          mismatches = 0, tests_run = 0, cycles = 0;
  // f = {word, dir, dst block, wide disp, base sel, index sel}
  // narrow index and based-index rows carry junk or zero high bytes so a missing sign extension shows
  aog_row_t    rows[12] = '{
    '{AOG_MODE_REGIND, 6'h00, 2'h0, 16'h0000, 16'h0100, 16'h0000},
    '{AOG_MODE_REGIND, 6'h00, 2'h1, 16'h0000, 16'h1000, 16'h0000},
    '{AOG_MODE_REGIND, 6'h00, 2'h3, 16'h0000, 16'hfff0, 16'h0000},
    '{AOG_MODE_INDEX, 6'h00, 2'h0, 16'h5580, 16'h0080, 16'h0000},
    '{AOG_MODE_INDEX, 6'h05, 2'h0, 16'h8000, 16'h9000, 16'h0000},
    '{AOG_MODE_BASED, 6'h02, 2'h0, 16'h0020, 16'h0010, 16'h0000},
    '{AOG_MODE_BASED, 6'h04, 2'h0, 16'hfffe, 16'h1ffe, 16'h0000},
    '{AOG_MODE_BASIDX, 6'h01, 2'h0, 16'h7705, 16'h3005, 16'h0000},
    '{AOG_MODE_BASIDX, 6'h02, 2'h0, 16'h00ff, 16'h00ef, 16'h0000},
    '{AOG_MODE_AUTO, 6'h28, 2'h0, 16'h0000, 16'h1000, 16'h1002},
    '{AOG_MODE_AUTO, 6'h10, 2'h0, 16'h0000, 16'h0100, 16'h00ff},
    '{AOG_MODE_AUTO, 6'h38, 2'h0, 16'h0000, 16'h1000, 16'h0ffe}};
  aog_row_t    sfr_row = '{AOG_MODE_SFR, 6'h00, 2'h0, 16'hff45, 16'h0000, 16'h0000};
  // second operand has the selected bit clear so set and invert both show
  logic [15:0] bexp[8] = '{16'h5a5a, 16'h5a5a, 16'h585a, 16'h585a,
                           16'ha5a5, 16'ha7a5, 16'ha5a5, 16'ha7a5};

  aog_top u_dut (.*);

  always #5 clk_i = ~clk_i;

  // ==========================================
  // shared tasks
  task automatic chk(input logic [23:0] s, input logic [23:0] e);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %0t got %h want %h", $time, s, e);
    end
  endtask

  task automatic op(input aog_row_t r);
    @(posedge clk_i);
    mode_i <= r.m;
    {word_i, direction_flag_i, block_dst_i, disp_wide_i, base_sel_i, index_sel_i} <= r.f;
    mem_sel_i <= r.ms;
    disp_i <= r.d;
    req_i <= 1'b1;
    @(posedge clk_i);
    req_i <= 1'b0;
    @(negedge clk_i);
  endtask

  task automatic wrap_up;
    if (mismatches == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ==========================================
  // hang guard, run needs under a hundred cycles
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      mismatches++;
      wrap_up();
    end
  end

  // ==========================================
  // main sequence
  initial begin
    {clk_i, req_i, word_i, direction_flag_i, disp_wide_i, base_sel_i, index_sel_i,
     block_dst_i, bit_test_clear_instr_i, bit_op_en_i, bit_from_count_i, mem_sel_i,
     count_low_byte_i, sfr_base_select_i, disp_i} = '0;
    sreg_field_i = 2'h2;
    mode_i = AOG_MODE_NONE;
    bit_op_i = AOG_BIT_TEST;
    sys_rst_i = 1'b1;
    block_rep_i = 1'b1;
    reg_field_i = 3'h5;
    bit_imm_i = 4'h9;
    operand_i = 16'h5a5a;
    repeat_counter_i = 16'h0003;
    source_index_i = 16'h0100;
    dest_index_i = 16'h1000;
    base_pointer_i = 16'h2000;
    base_word_i = 16'hfff0;
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(negedge clk_i);
    chk({done_o, ea_o, idx_we_o}, 24'h000000);
    foreach (rows[i]) begin
      op(rows[i]);
      chk(ea_o, rows[i].ea);
      chk(gpr_sel_o, {rows[i].f[5], 3'h5});
      chk({done_o, sreg_sel_o}, 24'h000006);
      if (rows[i].m == AOG_MODE_AUTO) begin
        chk({idx_we_o, idx_dst_o, idx_new_o},
            {1'b1, rows[i].f[3], rows[i].idx});
        chk({rep_we_o, rep_new_o}, 24'h010002);
      end
    end
    // last repetition must flag the end without wrapping
    @(posedge clk_i);
    repeat_counter_i <= 16'h0001;
    op(rows[9]);
    chk({rep_we_o, rep_last_o, rep_new_o}, 24'h030000);
    // an empty count is never stepped below zero
    @(posedge clk_i);
    repeat_counter_i <= 16'h0000;
    op(rows[9]);
    chk({rep_we_o, rep_last_o, rep_new_o}, 24'h010000);
    @(posedge clk_i);
    sfr_base_select_i <= 8'ha5;
    bit_test_clear_instr_i <= 1'b1;
    op(sfr_row);
    chk({is_sfr_o, sfr_addr_o}, 24'h1a5f45);
    chk(ea_o, 16'hff45);
    @(posedge clk_i);
    bit_test_clear_instr_i <= 1'b0;
    op(sfr_row);
    chk({illegal_o, is_sfr_o, sfr_addr_o}, 24'h200000);
    chk(ea_o, 16'h0000);
    @(posedge clk_i);
    bit_op_en_i <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_i);
      bit_op_i <= aog_bit_op_t'(k[1:0]);
      operand_i <= (k < 4) ? 16'h5a5a : 16'ha5a5;
      op(rows[9]);
      chk(bit_result_o, bexp[k]);
      chk({bit_val_o, bit_sel_o}, (k < 4) ? 24'h000019 : 24'h000009);
    end
    // byte operand keeps only three count bits, high byte untouched
    @(posedge clk_i);
    bit_from_count_i <= 1'b1;
    count_low_byte_i <= 8'hfb;
    operand_i <= 16'h5a5a;
    op(rows[10]);
    chk({bit_sel_o, bit_result_o}, 24'h035a52);
    // reset in mid-run clears every registered result
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(negedge clk_i);
    chk({ea_o, gpr_sel_o, bit_sel_o}, 24'h000000);
    op(rows[0]);
    chk(ea_o, rows[0].ea);
    wrap_up();
  end
endmodule
`default_nettype wire

// [verilog/aog_bit_unit.sv]
`timescale 1ns/1ps
`default_nettype none
`include "aog_defs.svh"

module aog_bit_unit
  import aog_pkg::*;
(
  input  wire logic [15:0] operand_i,
  input  wire logic        word_i,
  input  wire logic [3:0]  bit_num_i,
  input  wire aog_bit_op_t bit_op_i,
  output logic      [3:0]  bit_sel_o,
  output logic             bit_val_o,
  output logic      [15:0] result_o
);

  logic [3:0] sel;

  // ==========================================
  // bit number: byte operands use only the low three bits
  always_comb begin
    sel = word_i ? bit_num_i : {1'b0, bit_num_i[`AOG_BITNUM_BYTE-1:0]};
  end

  assign bit_sel_o = sel;
  assign bit_val_o = operand_i[sel];

  // ==========================================
  // only the selected bit may change
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_bit
      // one local bit per slice keeps each process the only writer of its variable
      logic nb;
      always_comb begin
        if (sel == 4'(gi)) begin
          case (bit_op_i)
            AOG_BIT_SET:    nb = 1'b1;
            AOG_BIT_CLEAR:  nb = 1'b0;
            AOG_BIT_INVERT: nb = ~operand_i[gi];
            default:        nb = operand_i[gi];
          endcase
        end else begin
          nb = operand_i[gi];
        end
      end
      assign result_o[gi] = nb;
    end
  endgenerate

endmodule
`default_nettype wire

// [verilog/aog_top.sv]
// How it works
// - address first, then step one or two
// - direction flag zero increments, one decrements
// - destination block uses dest index, source uses source
// - repeat counter counts block repetitions
// - index mode adds signed displacement to index
// - based mode adds signed displacement to base
// - based-index sums displacement, base and index
// - bit number from immediate or count low byte
// - bit ops touch only the selected bit
// - sfr immediate is unsigned window offset
// - sfr addressing only for bit test clear
// - sfr window upper bits from base select
// - register field plus word bit picks register
// - register indirect uses source, dest or base word
`timescale 1ns/1ps
`default_nettype none
`include "aog_defs.svh"

module aog_top
  import aog_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        req_i,
  input  wire aog_mode_t   mode_i,
  input  wire logic        word_i,
  input  wire logic        direction_flag_i,
  input  wire logic [15:0] disp_i,
  input  wire logic        disp_wide_i,
  input  wire logic        base_sel_i,
  input  wire logic        index_sel_i,
  input  wire logic [1:0]  mem_sel_i,
  input  wire logic        block_dst_i,
  input  wire logic        block_rep_i,
  input  wire logic [2:0]  reg_field_i,
  input  wire logic [1:0]  sreg_field_i,
  input  wire logic [15:0] source_index_i,
  input  wire logic [15:0] dest_index_i,
  input  wire logic [15:0] base_pointer_i,
  input  wire logic [15:0] base_word_i,
  input  wire logic [15:0] repeat_counter_i,
  input  wire logic [7:0]  count_low_byte_i,
  input  wire logic [7:0]  sfr_base_select_i,
  input  wire logic        bit_test_clear_instr_i,
  input  wire logic        bit_op_en_i,
  input  wire logic [3:0]  bit_imm_i,
  input  wire logic        bit_from_count_i,
  input  wire aog_bit_op_t bit_op_i,
  input  wire logic [15:0] operand_i,
  output logic             done_o,
  output logic      [15:0] ea_o,
  output logic      [19:0] sfr_addr_o,
  output logic             is_sfr_o,
  output logic             illegal_o,
  output logic      [15:0] idx_new_o,
  output logic             idx_we_o,
  output logic             idx_dst_o,
  output logic      [15:0] rep_new_o,
  output logic             rep_we_o,
  output logic             rep_last_o,
  output logic      [3:0]  gpr_sel_o,
  output logic      [1:0]  sreg_sel_o,
  output logic      [3:0]  bit_sel_o,
  output logic             bit_val_o,
  output logic      [15:0] bit_result_o
);

  aog_state_t state_reg;
  aog_state_t state_next;

  logic [15:0] disp_ext;
  logic [15:0] base_val;
  logic [15:0] index_val;
  logic [15:0] regind_val;
  logic [15:0] auto_val;
  logic [15:0] step;
  logic [3:0]  bit_num;
  logic [3:0]  bu_sel;
  logic        bu_val;
  logic [15:0] bu_result;

  // ==========================================
  // operand selection
  always_comb begin
    // short displacement is sign-extended, not zero-filled
    disp_ext   = disp_wide_i ? disp_i : {{8{disp_i[7]}}, disp_i[7:0]};
    base_val   = base_sel_i ? base_word_i : base_pointer_i;
    index_val  = index_sel_i ? dest_index_i : source_index_i;
    auto_val   = block_dst_i ? dest_index_i : source_index_i;
    step       = word_i ? `AOG_STEP_WORD : `AOG_STEP_BYTE;
    bit_num    = bit_from_count_i ? count_low_byte_i[3:0] : bit_imm_i;
    case (mem_sel_i)
      2'b00:   regind_val = source_index_i;
      2'b01:   regind_val = dest_index_i;
      default: regind_val = base_word_i;
    endcase
  end

  // ==========================================
  // bit selection and manipulation
  aog_bit_unit u_bit (
    .operand_i (operand_i),
    .word_i    (word_i),
    .bit_num_i (bit_num),
    .bit_op_i  (bit_op_i),
    .bit_sel_o (bu_sel),
    .bit_val_o (bu_val),
    .result_o  (bu_result)
  );

  // ==========================================
  // next state
  always_comb begin
    state_next      = state_reg;
    state_next.done = 1'b0;
    state_next.idx_we = 1'b0;
    state_next.rep_we = 1'b0;
    if (req_i) begin
      state_next.done     = 1'b1;
      state_next.is_sfr   = 1'b0;
      state_next.illegal  = 1'b0;
      state_next.idx_dst  = 1'b0;
      state_next.rep_last = 1'b0;
      state_next.ea       = `AOG_RST_WORD;
      state_next.sfr_addr = `AOG_RST_PHYS;
      state_next.gpr_sel  = {word_i, reg_field_i};
      state_next.sreg_sel = sreg_field_i;
      case (mode_i)
        AOG_MODE_REGIND: begin
          state_next.ea = regind_val;
        end
        AOG_MODE_AUTO: begin
          // memory sees the old value; the step is for the next element
          state_next.ea      = auto_val;
          state_next.idx_dst = block_dst_i;
          state_next.idx_we  = 1'b1;
          if (direction_flag_i) begin
            state_next.idx_new = auto_val - step;
          end else begin
            state_next.idx_new = auto_val + step;
          end
          if (block_rep_i) begin
            // a zero count is left alone so it never wraps to all ones
            state_next.rep_last = (repeat_counter_i <= 16'h0001);
            if (repeat_counter_i != `AOG_RST_WORD) begin
              state_next.rep_new = repeat_counter_i - 16'h0001;
              state_next.rep_we  = 1'b1;
            end else begin
              state_next.rep_new = repeat_counter_i;
            end
          end
        end
        AOG_MODE_INDEX: begin
          state_next.ea = index_val + disp_ext;
        end
        AOG_MODE_BASED: begin
          state_next.ea = base_val + disp_ext;
        end
        AOG_MODE_BASIDX: begin
          state_next.ea = base_val + index_val + disp_ext;
        end
        AOG_MODE_SFR: begin
          if (bit_test_clear_instr_i) begin
            state_next.is_sfr   = 1'b1;
            state_next.ea       = {`AOG_SFR_PAGE, `AOG_SFR_PAGE, disp_i[7:0]};
            state_next.sfr_addr = {sfr_base_select_i, `AOG_SFR_PAGE, disp_i[7:0]};
          end else begin
            state_next.illegal = 1'b1;
          end
        end
        AOG_MODE_DIRECT: begin
          state_next.ea = disp_i;
        end
        default: begin
          state_next.ea = `AOG_RST_WORD;
        end
      endcase
      if (bit_op_en_i) begin
        state_next.bit_sel    = bu_sel;
        state_next.bit_val    = bu_val;
        state_next.bit_result = bu_result;
      end else begin
        state_next.bit_sel    = 4'h0;
        state_next.bit_val    = 1'b0;
        state_next.bit_result = operand_i;
      end
    end
  end

  // ==========================================
  // state register
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================
  // outputs
  assign done_o       = state_reg.done;
  assign ea_o         = state_reg.ea;
  assign sfr_addr_o   = state_reg.sfr_addr;
  assign is_sfr_o     = state_reg.is_sfr;
  assign illegal_o    = state_reg.illegal;
  assign idx_new_o    = state_reg.idx_new;
  assign idx_we_o     = state_reg.idx_we;
  assign idx_dst_o    = state_reg.idx_dst;
  assign rep_new_o    = state_reg.rep_new;
  assign rep_we_o     = state_reg.rep_we;
  assign rep_last_o   = state_reg.rep_last;
  assign gpr_sel_o    = state_reg.gpr_sel;
  assign sreg_sel_o   = state_reg.sreg_sel;
  assign bit_sel_o    = state_reg.bit_sel;
  assign bit_val_o    = state_reg.bit_val;
  assign bit_result_o = state_reg.bit_result;

endmodule
`default_nettype wire
